/* File: src/tsst_pkg.sv */
// Package for the trigger settings state tracker
package tsst_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_POSITION = 8'h00;
  localparam logic [7:0] OFF_HOLDOFF = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0C;
  localparam logic [7:0] OFF_LEVEL_RANGE = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_STATE_CLEAR = 8'h18;
  localparam logic [7:0] OFF_VIDEO = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFF_PRETRIG = 8'h2C;
  // Position limits and record geometry
  localparam logic [4:0] POS_MIN = 5'h01;
  localparam logic [4:0] POS_MAX = 5'h1F;
  localparam logic [4:0] POS_RESET = 5'h10;
  localparam logic [10:0] RECORD_LAST = 11'h3FF;
  localparam int POS_SHIFT = 5;
  // Holdoff in sixteenths: 0..100*16
  localparam logic [10:0] HOLD_MAX = 11'h640;
  localparam logic [10:0] HOLD_MIN = 11'h000;
  // Level limits in sixteenth divisions
  localparam logic signed [15:0] LVL_CH_LIM = 16'sh0120;
  localparam logic signed [15:0] LVL_OTHER_LIM = 16'sh0090;
  // Interrupt status bits
  localparam int IRQ_WARN = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_AUTO = 2;
  localparam int IRQ_W = 3;
  // Control register fields
  localparam int CTL_SEL = 0;
  localparam int CTL_WARN_EN = 1;
  localparam int CTL_ERR_EN = 2;
  localparam int CTL_AUTO = 3;
  localparam int CTL_RATE_LSB = 8;
  // Trigger states, least to most advanced
  typedef enum logic [2:0] {
    ST_ARMED = 3'b000,
    ST_READY = 3'b001,
    ST_MAIN_TRIGGERED = 3'b010,
    ST_DELAYED_TRIGGERED = 3'b011,
    ST_SAVED = 3'b100
  } tsst_state_type;
  // Field choices
  typedef enum logic [1:0] {
    FC_FIELD_ONE = 2'b00,
    FC_FIELD_TWO = 2'b01,
    FC_ALTERNATE = 2'b10,
    FC_LINE_SELECT = 2'b11
  } tsst_field_type;
  // Status inputs from the acquisition system
  typedef struct packed {
    logic ready;
    logic main_triggered;
    logic delayed_triggered;
    logic saved;
  } tsst_acq_type;
  // Auto-level result
  typedef struct packed {
    logic valid;
    logic signed [15:0] min_level;
    logic signed [15:0] max_level;
  } tsst_level_autoset_type;
endpackage

/* File: src/tsst_top.sv */
// Trigger settings state tracker with AHB-Lite register slave
// Function
// - pretrigger N*32, post 1023-N*32 samples
// - position clamped 1..31, warn if enabled
// - holdoff 0..100 in sixteenth steps
// - holdoff clamped to boundary, warn request
// - timebase change resets holdoff minimum
// - select bit steers level and source
// - report min/max only after level_autoset
// - repeat level_autoset selection forces recompute
// - state holds most advanced since clear
// - state clear returns to armed
// - video setting without option ignored, error
// - interlaced four choices, progressive two
// - interlace indicator reflects detected input
// - level limited 18 or 9 divisions
// - ready allows manual trigger force
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tsst_top (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire tsst_pkg::tsst_acq_type acq, // Acquisition progress
  input wire tsst_pkg::tsst_level_autoset_type auto_res, // Level_autoset result
  input wire logic video_present, // Video option fitted
  input wire logic video_interlaced, // Detected interlaced input
  output logic [9:0] pretrig_count, // Samples before trigger
  output logic [9:0] posttrig_count, // Samples after trigger
  output logic [10:0] holdoff_out, // Holdoff, sixteenths
  output logic trigger_select_out, // 0 main, 1 delayed
  output logic signed [15:0] main_level_eff, // Effective main level
  output logic signed [15:0] delayed_level_eff, // Effective delayed
  output logic level_autoset_start, // Level_autoset cycle pulse
  output logic manual_trigger, // Forced trigger pulse
  output logic [1:0] field_choice_out, // Active field choice
  output logic irq // Interrupt level
);
  logic addr_valid_reg;
  logic write_reg;
  logic [7:0] addr_reg;
  logic wr_en;
  logic rd_en;
  logic [4:0] position_reg;
  logic [10:0] holdoff_reg;
  logic [3:0] control_reg;
  logic [7:0] rate_reg;
  logic signed [15:0] main_level_reg;
  logic signed [15:0] delayed_level_reg;
  logic main_src_ch_reg;
  logic delayed_src_ch_reg;
  logic signed [15:0] min_reg;
  logic signed [15:0] max_reg;
  logic range_valid_reg;
  tsst_pkg::tsst_state_type state_reg;
  tsst_pkg::tsst_state_type state_next;
  tsst_pkg::tsst_field_type ifield_reg;
  tsst_pkg::tsst_field_type pfield_reg;
  logic [tsst_pkg::IRQ_W-1:0] irq_status_reg;
  logic [tsst_pkg::IRQ_W-1:0] irq_enable_reg;
  logic [tsst_pkg::IRQ_W-1:0] irq_set;
  logic warn_req;
  logic err_req;
  logic auto_req;
  logic signed [31:0] wsig;
  logic signed [15:0] lvl_in;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_valid_reg <= 1'b0;
      write_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready) begin
      addr_valid_reg <= hsel & htrans[1];
      write_reg <= hwrite;
      addr_reg <= haddr;
    end
  end

  assign wr_en = addr_valid_reg & write_reg;
  assign rd_en = hsel & htrans[1] & ~hwrite & hready;
  assign wsig = hwdata;
  assign lvl_in = hwdata[15:0];

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Position register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      position_reg <= tsst_pkg::POS_RESET;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_POSITION) begin
      if (wsig < $signed({27'h0, tsst_pkg::POS_MIN}))
        position_reg <= tsst_pkg::POS_MIN;
      else if (wsig > $signed({27'h0, tsst_pkg::POS_MAX}))
        position_reg <= tsst_pkg::POS_MAX;
      else
        position_reg <= hwdata[4:0];
    end
  end

  // Holdoff register and timebase reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holdoff_reg <= tsst_pkg::HOLD_MIN;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_CONTROL &&
                 hwdata[tsst_pkg::CTL_RATE_LSB +: 8] != rate_reg) begin
      holdoff_reg <= tsst_pkg::HOLD_MIN;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_HOLDOFF) begin
      if (wsig < 0)
        holdoff_reg <= tsst_pkg::HOLD_MIN;
      else if (wsig > $signed({21'h0, tsst_pkg::HOLD_MAX}))
        holdoff_reg <= tsst_pkg::HOLD_MAX;
      else
        holdoff_reg <= hwdata[10:0];
    end
  end

  // Warning request from clamped settings
  // warning on clamp
  always_comb begin
    warn_req = 1'b0;
    if (wr_en && addr_reg == tsst_pkg::OFF_POSITION &&
        (wsig < $signed({27'h0, tsst_pkg::POS_MIN}) ||
         wsig > $signed({27'h0, tsst_pkg::POS_MAX})))
      warn_req = control_reg[tsst_pkg::CTL_WARN_EN];
    if (wr_en && addr_reg == tsst_pkg::OFF_HOLDOFF &&
        (wsig < 0 || wsig > $signed({21'h0, tsst_pkg::HOLD_MAX})))
      warn_req = control_reg[tsst_pkg::CTL_WARN_EN];
  end

  // Control: select, report enables, level_autoset mode, rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= 4'h0;
      rate_reg <= 8'h00;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_CONTROL) begin
      control_reg <= hwdata[3:0];
      rate_reg <= hwdata[tsst_pkg::CTL_RATE_LSB +: 8];
    end
  end

  assign auto_req = wr_en && addr_reg == tsst_pkg::OFF_CONTROL &&
                    hwdata[tsst_pkg::CTL_AUTO] &&
                    control_reg[tsst_pkg::CTL_AUTO];

  // Level_autoset start pulse and range capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_autoset_start <= 1'b0;
      range_valid_reg <= 1'b0;
      min_reg <= 16'sh0000;
      max_reg <= 16'sh0000;
    end else begin
      level_autoset_start <= auto_req;
      if (auto_req || !control_reg[tsst_pkg::CTL_AUTO])
        range_valid_reg <= 1'b0;
      else if (auto_res.valid) begin
        range_valid_reg <= 1'b1;
        min_reg <= auto_res.min_level;
        max_reg <= auto_res.max_level;
      end
    end
  end

  // Trigger level settings and sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_level_reg <= 16'sh0000;
      delayed_level_reg <= 16'sh0000;
      main_src_ch_reg <= 1'b1;
      delayed_src_ch_reg <= 1'b1;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_LEVEL) begin
      if (control_reg[tsst_pkg::CTL_SEL]) begin
        delayed_level_reg <= lvl_in;
        delayed_src_ch_reg <= hwdata[16];
      end else begin
        main_level_reg <= lvl_in;
        main_src_ch_reg <= hwdata[16];
      end
    end
  end

  // Limit a level to the source's span
  function automatic logic signed [15:0] lim(
    input logic signed [15:0] v, input logic ch);
    logic signed [15:0] l;
    l = ch ? tsst_pkg::LVL_CH_LIM : tsst_pkg::LVL_OTHER_LIM;
    if (v > l) lim = l;
    else if (v < -l) lim = -l;
    else lim = v;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_level_eff <= 16'sh0000;
      delayed_level_eff <= 16'sh0000;
    end else begin
      main_level_eff <= lim(main_level_reg, main_src_ch_reg);
      delayed_level_eff <= lim(delayed_level_reg, delayed_src_ch_reg);
    end
  end

  always_comb begin
    state_next = state_reg;
    if (acq.saved) state_next = tsst_pkg::ST_SAVED;
    else if (acq.delayed_triggered &&
             state_reg < tsst_pkg::ST_DELAYED_TRIGGERED)
      state_next = tsst_pkg::ST_DELAYED_TRIGGERED;
    else if (acq.main_triggered &&
             state_reg < tsst_pkg::ST_MAIN_TRIGGERED)
      state_next = tsst_pkg::ST_MAIN_TRIGGERED;
    else if (acq.ready && state_reg < tsst_pkg::ST_READY)
      state_next = tsst_pkg::ST_READY;
  end

  // Trigger state variable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= tsst_pkg::ST_ARMED;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_STATE_CLEAR) begin
      state_reg <= tsst_pkg::ST_ARMED;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      manual_trigger <= 1'b0;
    end else begin
      manual_trigger <= wr_en && addr_reg == tsst_pkg::OFF_STATE &&
                        hwdata[0] && state_reg == tsst_pkg::ST_READY;
    end
  end

  // Video field settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ifield_reg <= tsst_pkg::FC_FIELD_ONE;
      pfield_reg <= tsst_pkg::FC_FIELD_ONE;
    end else if (wr_en && addr_reg == tsst_pkg::OFF_VIDEO &&
                 video_present) begin
      ifield_reg <= tsst_pkg::tsst_field_type'(hwdata[1:0]);
      if (hwdata[5:4] == tsst_pkg::FC_FIELD_ONE ||
          hwdata[5:4] == tsst_pkg::FC_LINE_SELECT)
        pfield_reg <= tsst_pkg::tsst_field_type'(hwdata[5:4]);
    end
  end

  assign err_req = wr_en && addr_reg == tsst_pkg::OFF_VIDEO &&
                   !video_present && control_reg[tsst_pkg::CTL_ERR_EN];

  // Active field choice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_choice_out <= 2'h0;
    end else begin
      field_choice_out <= video_interlaced ? ifield_reg : pfield_reg;
    end
  end

  // Interrupt status, set wins over clear
  assign irq_set = {range_valid_reg == 1'b0 && auto_res.valid &&
                    control_reg[tsst_pkg::CTL_AUTO], err_req, warn_req};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= 3'h0;
      irq_enable_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_en && addr_reg == tsst_pkg::OFF_IRQ_CLEAR)
        irq_status_reg <= (irq_status_reg & ~hwdata[2:0]) | irq_set;
      else
        irq_status_reg <= irq_status_reg | irq_set;
      if (wr_en && addr_reg == tsst_pkg::OFF_IRQ_ENABLE)
        irq_enable_reg <= hwdata[2:0];
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pretrig_count <= 10'h000;
      posttrig_count <= 10'h000;
      holdoff_out <= 11'h000;
      trigger_select_out <= 1'b0;
    end else begin
      pretrig_count <= 10'({position_reg, 5'h00});
      posttrig_count <= 10'(tsst_pkg::RECORD_LAST -
                            11'({position_reg, 5'h00}));
      holdoff_out <= holdoff_reg;
      trigger_select_out <= control_reg[tsst_pkg::CTL_SEL];
    end
  end

  // Read data mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (haddr)
        tsst_pkg::OFF_POSITION: hrdata <= {27'h0, position_reg};
        tsst_pkg::OFF_HOLDOFF: hrdata <= {21'h0, holdoff_reg};
        tsst_pkg::OFF_CONTROL: hrdata <= {16'h0, rate_reg, 4'h0,
                                          control_reg};
        tsst_pkg::OFF_LEVEL: hrdata <= control_reg[tsst_pkg::CTL_SEL] ?
          {16'h0, delayed_level_reg} : {16'h0, main_level_reg};
        tsst_pkg::OFF_LEVEL_RANGE: hrdata <= range_valid_reg ?
          {max_reg, min_reg} : 32'h0000_0000;
        tsst_pkg::OFF_STATE: hrdata <= {29'h0, state_reg};
        tsst_pkg::OFF_VIDEO: hrdata <= {24'h0, video_interlaced,
          video_present, pfield_reg, 2'h0, ifield_reg};
        tsst_pkg::OFF_IRQ_STATUS: hrdata <= {29'h0, irq_status_reg};
        tsst_pkg::OFF_IRQ_ENABLE: hrdata <= {29'h0, irq_enable_reg};
        tsst_pkg::OFF_PRETRIG: hrdata <= {22'h0, pretrig_count};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  AST_POS_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    position_reg >= tsst_pkg::POS_MIN && position_reg <= tsst_pkg::POS_MAX)
    else $error("position out of range");
  AST_HOLD_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    holdoff_reg <= tsst_pkg::HOLD_MAX)
    else $error("holdoff out of range");
  AST_SPLIT: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> pretrig_count + posttrig_count ==
    10'(tsst_pkg::RECORD_LAST))
    else $error("record split wrong");
  AST_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(rate_reg) |-> holdoff_reg == tsst_pkg::HOLD_MIN)
    else $error("holdoff not reset");
  AST_MONO: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_en && addr_reg == tsst_pkg::OFF_STATE_CLEAR) |=>
    state_reg >= $past(state_reg))
    else $error("state regressed");
  AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && addr_reg == tsst_pkg::OFF_STATE_CLEAR |=>
    state_reg == tsst_pkg::ST_ARMED)
    else $error("state not cleared");
  AST_VIDEO: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && addr_reg == tsst_pkg::OFF_VIDEO && !video_present |=>
    $stable(ifield_reg) && $stable(pfield_reg))
    else $error("video write not ignored");
  AST_ERRIRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    err_req |=> irq_status_reg[tsst_pkg::IRQ_ERR])
    else $error("error not flagged");
  AST_PFIELD: assert property (@(posedge hclk) disable iff (!hresetn)
    pfield_reg != tsst_pkg::FC_FIELD_TWO &&
    pfield_reg != tsst_pkg::FC_ALTERNATE)
    else $error("bad progressive field");
  AST_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    main_level_eff <= tsst_pkg::LVL_CH_LIM &&
    main_level_eff >= -tsst_pkg::LVL_CH_LIM)
    else $error("level not limited");
  AST_AUTO: assert property (@(posedge hclk) disable iff (!hresetn)
    auto_req |=> level_autoset_start ##1 !level_autoset_start)
    else $error("level_autoset pulse wrong");
  COV_CLAMP: cover property (@(posedge hclk) warn_req);
  COV_SAVE: cover property (@(posedge hclk)
    state_reg == tsst_pkg::ST_SAVED);
  COV_MAN: cover property (@(posedge hclk) manual_trigger);
  COV_AUTO: cover property (@(posedge hclk) level_autoset_start);
endmodule // tsst_top

/* File: test/tsst_ctrl_model.sv */
// Register bus master standing in for the remote command controller
`timescale 1ns/1ps
module tsst_ctrl_model (
  input wire logic hclk, // Bus clock
  input wire logic hready, // Bus ready
  output logic hsel, // Slave select
  output logic [7:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write flag
  output logic [2:0] hsize, // Always a word
  output logic [31:0] hwdata // Write data
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single transfer after gap idle cycles; ok drops on a hang
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input int gap, output bit ok);
    int n;
    ok = 1'b1;
    repeat (gap + 1) @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 128);
    // Released data lines show the inverse, not a stale copy
    hwdata <= ~d;
    if (n >= 64) ok = 1'b0;
  endtask
endmodule // tsst_ctrl_model

/* File: test/tsst_top_bench.sv */
// Self-checking bench for the trigger settings state tracker
`timescale 1ns/1ps
module tsst_top_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  tsst_pkg::tsst_acq_type acq = '0;
  tsst_pkg::tsst_level_autoset_type auto_res = '0;
  logic video_present = 1'b0;
  logic video_interlaced = 1'b0;
  logic [9:0] pretrig_count, posttrig_count;
  logic [10:0] holdoff_out;
  logic trigger_select_out, level_autoset_start, manual_trigger;
  logic signed [15:0] main_level_eff, delayed_level_eff;
  logic [1:0] field_choice_out;
  logic [63:0] expq[$];
  logic rd_dph = 1'b0;
  logic [15:0] lmin, lmax, lv;
  logic [63:0] note;
  int miscompares = 0;
  int samples_checked = 0;
  int n_auto = 0;
  int n_man = 0;
  int na, e;
  int pos_tbl[6] = '{0, 1, 31, 32, 200, 5};
  int hold_tbl[4] = '{-5, 1601, 800, 0};
  int hold_exp[4] = '{0, 1600, 800, 0};
  logic [3:0] acq_tbl[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8};
  int st_exp[5] = '{1, 2, 3, 4, 4};
  int prog_tbl[4] = '{0, 1, 3, 2};
  int prog_exp[4] = '{0, 0, 3, 3};

  tsst_ctrl_model m (.hclk(hclk), .hready(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  tsst_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .acq(acq), .auto_res(auto_res),
    .video_present(video_present), .video_interlaced(video_interlaced),
    .pretrig_count(pretrig_count), .posttrig_count(posttrig_count),
    .holdoff_out(holdoff_out), .trigger_select_out(trigger_select_out),
    .main_level_eff(main_level_eff), .delayed_level_eff(delayed_level_eff),
    .level_autoset_start(level_autoset_start),
    .manual_trigger(manual_trigger), .field_choice_out(field_choice_out),
    .irq(irq));

  // Clock at 50 ns period
  initial begin
    forever #25 hclk = ~hclk;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ok;
    m.xfer(1'b1, a, d, $urandom_range(0, 2), ok);
    if (!ok) begin
      miscompares++;
      end_of_test();
    end
  endtask

  // Notes the expected word and mask; the monitor compares
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
      input logic [31:0] mk);
    bit ok;
    expq.push_back({mk, v});
    m.xfer(1'b0, a, 32'h0, $urandom_range(0, 2), ok);
    if (!ok) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge hclk);
    #1;
  endtask

  function automatic logic [31:0] ctl(input logic s, input logic au,
      input logic [7:0] rate);
    return {16'h0, rate, 4'h0, au, 1'b1, 1'b1, s};
  endfunction

  // Read data monitor: oldest note against the data phase result
  always @(posedge hclk) begin
    if (rd_dph && hreadyout) begin
      note = expq.pop_front();
      check(hrdata & note[63:32], note[31:0]);
    end
    rd_dph <= hsel & htrans[1] & ~hwrite & hreadyout;
  end

  // Acquisition side: prompt level_autoset result, pulse counters
  always @(posedge hclk) begin
    auto_res <= {level_autoset_start, lmin, lmax};
    if (level_autoset_start) n_auto++;
    if (manual_trigger) n_man++;
  end

  // Hang guard
  initial begin
    #4000000;
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(82912));
    lmin = 16'hFF00;
    lmax = 16'h0080;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(tsst_pkg::OFF_POSITION, 32'h10, 32'hFFFFFFFF);
    settle();
    check({22'h0, pretrig_count}, 32'h200);
    check({22'h0, posttrig_count}, 32'h1FF);
    check({31'h0, hresp}, 32'h0);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF);
    wr(tsst_pkg::OFF_IRQ_ENABLE, 32'h7);
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, 8'h01));
    // Position boundaries and a random legal value
    pos_tbl[5] = $urandom_range(1, 31);
    for (int i = 0; i < 6; i++) begin
      e = pos_tbl[i] < 1 ? 1 : (pos_tbl[i] > 31 ? 31 : pos_tbl[i]);
      wr(tsst_pkg::OFF_IRQ_CLEAR, 32'h7);
      wr(tsst_pkg::OFF_POSITION, 32'(pos_tbl[i]));
      rd(tsst_pkg::OFF_POSITION, 32'(e), 32'hFFFFFFFF);
      settle();
      check({22'h0, pretrig_count}, 32'(e * 32));
      check({22'h0, posttrig_count}, 32'(1023 - e * 32));
      check({31'h0, irq}, {31'h0, e != pos_tbl[i]});
      rd(tsst_pkg::OFF_IRQ_STATUS, {31'h0, e != pos_tbl[i]}, 32'h1);
    end
    // Masked warning still sets status, irq stays low
    wr(tsst_pkg::OFF_IRQ_ENABLE, 32'h0);
    wr(tsst_pkg::OFF_POSITION, 32'h0);
    settle();
    check({31'h0, irq}, 32'h0);
    rd(tsst_pkg::OFF_IRQ_STATUS, 32'h1, 32'h1);
    wr(tsst_pkg::OFF_IRQ_ENABLE, 32'h7);
    // Holdoff clamp table
    for (int i = 0; i < 4; i++) begin
      wr(tsst_pkg::OFF_IRQ_CLEAR, 32'h7);
      wr(tsst_pkg::OFF_HOLDOFF, 32'(hold_tbl[i]));
      settle();
      check({21'h0, holdoff_out}, 32'(hold_exp[i]));
      rd(tsst_pkg::OFF_IRQ_STATUS, {31'h0, i < 2}, 32'h1);
    end
    // Timebase rewrite keeps holdoff, a change resets it
    wr(tsst_pkg::OFF_HOLDOFF, 32'h320);
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, 8'h01));
    settle();
    check({21'h0, holdoff_out}, 32'h320);
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, 8'h02));
    settle();
    check({21'h0, holdoff_out}, 32'h0);
    // Levels steered by the select bit, clamped per source
    for (int s = 0; s < 2; s++) begin
      wr(tsst_pkg::OFF_CONTROL, ctl(s[0], 1'b0, 8'h02));
      wr(tsst_pkg::OFF_LEVEL, 32'h000103E8);
      settle();
      check({31'h0, trigger_select_out}, 32'(s));
      lv = s ? delayed_level_eff : main_level_eff;
      check({16'h0, lv}, 32'h0120);
      wr(tsst_pkg::OFF_LEVEL, 32'h0000FC18);
      settle();
      lv = s ? delayed_level_eff : main_level_eff;
      check({16'h0, lv}, 32'hFF70);
    end
    lv = 16'($urandom_range(0, 576)) - 16'h0120;
    wr(tsst_pkg::OFF_LEVEL, {15'h0, 1'b1, lv});
    settle();
    check({16'h0, delayed_level_eff}, {16'h0, lv});
    check({16'h0, main_level_eff}, 32'hFF70);
    // Repeated level_autoset selection forces one new cycle
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b1, 8'h02));
    settle();
    na = n_auto;
    wr(tsst_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b1, 8'h02));
    settle();
    check(32'(n_auto), 32'(na + 1));
    rd(tsst_pkg::OFF_LEVEL_RANGE, {lmax, lmin}, 32'hFFFFFFFF);
    rd(tsst_pkg::OFF_IRQ_STATUS, 32'h4, 32'h4);
    wr(tsst_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, 8'h02));
    rd(tsst_pkg::OFF_LEVEL_RANGE, 32'h0, 32'hFFFFFFFF);
    // Trigger state climbs and never falls back
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk) acq <= tsst_pkg::tsst_acq_type'(acq_tbl[i]);
      settle();
      rd(tsst_pkg::OFF_STATE, 32'(st_exp[i]), 32'h7);
      if (i == 0) begin
        na = n_man;
        wr(tsst_pkg::OFF_STATE, 32'h1);
        settle();
        check(32'(n_man), 32'(na + 1));
      end
    end
    @(posedge hclk) acq <= '0;
    wr(tsst_pkg::OFF_STATE_CLEAR, 32'h1);
    rd(tsst_pkg::OFF_STATE, 32'h0, 32'h7);
    na = n_man;
    wr(tsst_pkg::OFF_STATE, 32'h1);
    settle();
    check(32'(n_man), 32'(na));
    // Video settings without the option are refused
    wr(tsst_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(tsst_pkg::OFF_VIDEO, 32'h2);
    settle();
    check({30'h0, field_choice_out}, 32'h0);
    rd(tsst_pkg::OFF_IRQ_STATUS, 32'h2, 32'h2);
    rd(tsst_pkg::OFF_VIDEO, 32'h0, 32'h43);
    // Interlaced choices, all four
    @(posedge hclk) video_present <= 1'b1;
    video_interlaced <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(tsst_pkg::OFF_VIDEO, 32'(c));
      settle();
      check({30'h0, field_choice_out}, 32'(c));
      rd(tsst_pkg::OFF_VIDEO, 32'hC0 | 32'(c), 32'hC3);
    end
    // Progressive accepts field one and line select only
    @(posedge hclk) video_interlaced <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(tsst_pkg::OFF_VIDEO, 32'((prog_tbl[i] << 4) | 3));
      settle();
      check({30'h0, field_choice_out}, 32'(prog_exp[i]));
      rd(tsst_pkg::OFF_VIDEO, 32'h40 | 32'(prog_exp[i] << 4), 32'hF0);
    end
    settle();
    end_of_test();
  end
endmodule // tsst_top_bench
